//--- gst_pkg.sv
// constants shared by the gated sixteen bit timer files
package gst_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_COUNT_LOW   = 3'h0;
  localparam logic [2:0] ADDR_COUNT_HIGH  = 3'h1;
  localparam logic [2:0] ADDR_TIMER_CTRL  = 3'h2;
  localparam logic [2:0] ADDR_GATE_CTRL   = 3'h3;
  localparam logic [2:0] ADDR_IRQ_STATUS  = 3'h4;
  localparam logic [2:0] ADDR_IRQ_MASK    = 3'h5;
  // timer control field positions
  localparam int TCTL_CLK_SEL_LSB   = 6;
  localparam int TCTL_PRESCALE_LSB  = 4;
  localparam int TCTL_SYNC_DIS_BIT  = 2;
  localparam int TCTL_TIMER_ON_BIT  = 0;
  // gate control field positions
  localparam int GCTL_GATE_EN_BIT   = 7;
  localparam int GCTL_GATE_POL_BIT  = 6;
  localparam int GCTL_GATE_SRC_LSB  = 0;
  // status and mask bit of the overflow event
  localparam int IRQ_OVF_BIT        = 0;
  // values after reset, and the count at which the counter wraps
  localparam logic [7:0]  TCTL_RESET  = 8'h00;
  localparam logic [7:0]  GCTL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  // clock select codes
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYS   = 2'h1;
  localparam logic [1:0] CS_EXT   = 2'h2;
  localparam logic [1:0] CS_SLOW  = 2'h3;
  // gate source codes
  localparam logic [1:0] GS_PIN   = 2'h0;
  localparam logic [1:0] GS_WRAP  = 2'h1;
  localparam logic [1:0] GS_CMP1  = 2'h2;
  localparam logic [1:0] GS_CMP2  = 2'h3;
  // last system clock cycle of each four cycle instruction cycle, and prescaler width
  localparam logic [1:0] INSTR_LAST = 2'h3;
  localparam int         PRESC_W    = 3;
endpackage

//--- gst_presc.sv
// prescaler: divides qualified count ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
module gst_presc #(
  parameter int W = gst_pkg::PRESC_W
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // control
  input  wire logic         clr,
  input  wire logic [1:0]   sel,
  // ticks
  input  wire logic         tick_in,
  output logic              tick_out,
  output logic [W-1:0]      cnt
);
  logic [W-1:0] mask;
  logic [W-1:0] cnt_r;

  // low bits that must all be set before a tick passes
  always_comb
  begin
    mask = W'((4'h1 << sel) - 4'h1);
  end

  assign tick_out = tick_in && ((cnt_r & mask) == mask);
  assign cnt      = cnt_r;

  // hidden counter: reset or a count byte write clears it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cnt_r <= '0;
    else if (clr)
      cnt_r <= '0;
    else if (tick_in)
      cnt_r <= cnt_r + W'(1);
  end
endmodule

//--- gst_timer.sv
// gated sixteen bit timer/counter with register port and overflow interrupt
//
// Functional notes
// - sixteen bit counter, byte writes replace count
// - on bit and gate enable decide counting
// - clock select picks count source
// - instruction clock advances once per instruction
// - system clock advances four per instruction
// - external pin counts rising edges
// - rising edge ignored until falling edge seen
// - prescaler divides by 1, 2, 4, 8
// - prescaler hidden, cleared by count writes
// - sync disable counts pin through two synchroniser stages instead of three
// - asynchronous external mode runs during sleep
// - mode switch may lose or add count
// - byte reads always valid while running
// - gate source pin, wrap, comparator one
// - gate source code 11 selects comparator two
// - gate polarity picks active gate level
`timescale 1ns/1ps
module gst_timer (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // register port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  // count sources
  input  wire logic       external_count_pin,
  input  wire logic       slow_internal_oscillator,
  // gate sources
  input  wire logic       gate_input_pin,
  input  wire logic       other_timer_wrap_pulse,
  input  wire logic       comparator_one_output,
  input  wire logic       comparator_two_output,
  // power state
  input  wire logic       sleep_mode,
  // interrupt
  output logic            irq
);
  logic [15:0] count_r;
  logic [7:0]  tctl_r;
  logic [7:0]  gctl_r;
  logic        ovf_r;
  logic        ovf_mask_r;
  logic [7:0]  rdata_r;
  logic [1:0]  instr_cnt_r;
  logic        ext_s1_r;
  logic        ext_s2_r;
  logic        ext_s3_r;
  logic        ext_prev_r;
  logic        slow_s1_r;
  logic        slow_s2_r;
  logic        slow_prev_r;
  logic        gpin_s1_r;
  logic        gpin_s2_r;
  logic        cmp2_s1_r;
  logic        cmp2_s2_r;
  logic        arm_r;
  logic        ext_sel;
  logic        ext_rise;
  logic        ext_fall;
  logic        slow_rise;
  logic        instr_tick;
  logic        timer_on;
  logic        gate_en;
  logic        gate_pol;
  logic        sync_dis;
  logic [1:0]  clk_sel;
  logic [1:0]  presc_sel;
  logic [1:0]  gate_src;
  logic        gate_sig;
  logic        gate_ok;
  logic        count_en;
  logic        src_tick;
  logic        inc;
  logic        wr_low;
  logic        wr_high;
  logic        wr_count;
  logic        ovf_event;
  logic [gst_pkg::PRESC_W-1:0] presc_cnt;

  // control field decode
  assign timer_on  = tctl_r[gst_pkg::TCTL_TIMER_ON_BIT];
  assign sync_dis  = tctl_r[gst_pkg::TCTL_SYNC_DIS_BIT];
  assign clk_sel   = tctl_r[gst_pkg::TCTL_CLK_SEL_LSB +: 2];
  assign presc_sel = tctl_r[gst_pkg::TCTL_PRESCALE_LSB +: 2];
  assign gate_en   = gctl_r[gst_pkg::GCTL_GATE_EN_BIT];
  assign gate_pol  = gctl_r[gst_pkg::GCTL_GATE_POL_BIT];
  assign gate_src  = gctl_r[gst_pkg::GCTL_GATE_SRC_LSB +: 2];

  // write strobes for the count bytes
  assign wr_low   = wr_en && (addr == gst_pkg::ADDR_COUNT_LOW);
  assign wr_high  = wr_en && (addr == gst_pkg::ADDR_COUNT_HIGH);
  assign wr_count = wr_low || wr_high;

  // pin synchronisers; third external stage only used in sync mode
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_s1_r  <= 1'b0;
      ext_s2_r  <= 1'b0;
      ext_s3_r  <= 1'b0;
      slow_s1_r <= 1'b0;
      slow_s2_r <= 1'b0;
      gpin_s1_r <= 1'b0;
      gpin_s2_r <= 1'b0;
      cmp2_s1_r <= 1'b0;
      cmp2_s2_r <= 1'b0;
    end
    else
    begin
      ext_s1_r  <= external_count_pin;
      ext_s2_r  <= ext_s1_r;
      ext_s3_r  <= ext_s2_r;
      slow_s1_r <= slow_internal_oscillator;
      slow_s2_r <= slow_s1_r;
      gpin_s1_r <= gate_input_pin;
      gpin_s2_r <= gpin_s1_r;
      cmp2_s1_r <= comparator_two_output;
      cmp2_s2_r <= cmp2_s1_r;
    end
  end

  // async mode skips the extra stage, so a mode change may skip or add an edge
  assign ext_sel = sync_dis ? ext_s2_r : ext_s3_r;

  // edge history of the selected pin and the slow oscillator
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_prev_r  <= 1'b0;
      slow_prev_r <= 1'b0;
    end
    else
    begin
      ext_prev_r  <= ext_sel;
      slow_prev_r <= slow_s2_r;
    end
  end

  assign ext_rise  = ext_sel && !ext_prev_r;
  assign ext_fall  = !ext_sel && ext_prev_r;
  assign slow_rise = slow_s2_r && !slow_prev_r;

  // falling edge arms the counter; disable or count write disarms it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      arm_r <= 1'b0;
    else if (!timer_on || wr_count)
      arm_r <= 1'b0;
    else if (ext_fall)
      arm_r <= 1'b1;
  end

  // instruction clock divider; the core clock stops in sleep
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      instr_cnt_r <= 2'h0;
    else if (!sleep_mode)
      instr_cnt_r <= instr_cnt_r + 2'h1;
  end

  assign instr_tick = (instr_cnt_r == gst_pkg::INSTR_LAST);

  // count source select
  always_comb
  begin
    case (clk_sel)
      gst_pkg::CS_INSTR: src_tick = instr_tick && !sleep_mode;
      gst_pkg::CS_SYS:   src_tick = !sleep_mode;
      // synchronised counting needs the core clock, async keeps going in sleep
      gst_pkg::CS_EXT:   src_tick = ext_rise && arm_r && (sync_dis || !sleep_mode);
      gst_pkg::CS_SLOW:  src_tick = slow_rise;
      default:           src_tick = 1'b0;
    endcase
  end

  // gate source select
  always_comb
  begin
    case (gate_src)
      gst_pkg::GS_PIN:  gate_sig = gpin_s2_r;
      gst_pkg::GS_WRAP: gate_sig = other_timer_wrap_pulse;
      gst_pkg::GS_CMP1: gate_sig = comparator_one_output;
      gst_pkg::GS_CMP2: gate_sig = cmp2_s2_r;
      default:          gate_sig = 1'b0;
    endcase
  end

  assign gate_ok  = gate_pol ? gate_sig : !gate_sig;
  assign count_en = timer_on && (!gate_en || gate_ok);

  // gated ticks feed the hidden prescaler
  gst_presc #(
    .W        (gst_pkg::PRESC_W)
  ) u_presc (
    .core_clk (core_clk),
    .rst      (rst),
    .clr      (wr_count),
    .sel      (presc_sel),
    .tick_in  (src_tick && count_en),
    .tick_out (inc),
    .cnt      (presc_cnt)
  );

  assign ovf_event = inc && !wr_count && (count_r == gst_pkg::COUNT_MAX);

  // counter; a byte write wins over an increment in the same cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count_r <= gst_pkg::COUNT_RESET;
    else if (wr_low)
      count_r <= {count_r[15:8], wdata};
    else if (wr_high)
      count_r <= {wdata, count_r[7:0]};
    else if (inc)
      count_r <= count_r + 16'h0001;
  end

  // control registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tctl_r     <= gst_pkg::TCTL_RESET;
      gctl_r     <= gst_pkg::GCTL_RESET;
      ovf_mask_r <= 1'b0;
    end
    else if (wr_en)
    begin
      if (addr == gst_pkg::ADDR_TIMER_CTRL)
        tctl_r <= wdata & 8'hF5;
      if (addr == gst_pkg::ADDR_GATE_CTRL)
        gctl_r <= wdata & 8'hC3;
      if (addr == gst_pkg::ADDR_IRQ_MASK)
        ovf_mask_r <= wdata[gst_pkg::IRQ_OVF_BIT];
    end
  end

  // sticky overflow flag, write one clears, a new wrap wins
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ovf_r <= 1'b0;
    else if (ovf_event)
      ovf_r <= 1'b1;
    else if (wr_en && (addr == gst_pkg::ADDR_IRQ_STATUS) && wdata[gst_pkg::IRQ_OVF_BIT])
      ovf_r <= 1'b0;
  end

  // level interrupt, also serves as the wake request in sleep
  assign irq = ovf_r && ovf_mask_r;

  // read data; each byte is a clocked copy of the live count, so the two bytes can come from different words
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else if (rd_en)
    begin
      case (addr)
        gst_pkg::ADDR_COUNT_LOW:  rdata_r <= count_r[7:0];
        gst_pkg::ADDR_COUNT_HIGH: rdata_r <= count_r[15:8];
        gst_pkg::ADDR_TIMER_CTRL: rdata_r <= tctl_r;
        gst_pkg::ADDR_GATE_CTRL:  rdata_r <= gctl_r;
        gst_pkg::ADDR_IRQ_STATUS: rdata_r <= {7'h00, ovf_r};
        gst_pkg::ADDR_IRQ_MASK:   rdata_r <= {7'h00, ovf_mask_r};
        default:                  rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  assign rdata = rdata_r;

  // checks next to the logic they guard
  low_write_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_low |=> (count_r[7:0] == $past(wdata)) && (count_r[15:8] == $past(count_r[15:8])))
    else $error("low byte write not applied");

  off_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (!timer_on && !wr_count) |=> (count_r == $past(count_r)))
    else $error("counter moved while off");

  gate_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (timer_on && gate_en && (gate_pol != gate_sig) && !wr_count) |=> $stable(count_r))
    else $error("counter moved with gate inactive");

  sys_step_a: assert property (@(posedge core_clk) disable iff (rst)
    (timer_on && !gate_en && clk_sel == gst_pkg::CS_SYS && presc_sel == 2'h0
     && !sleep_mode && !wr_count) |=> (count_r == $past(count_r) + 16'h0001))
    else $error("system clock count did not advance");

  instr_rate_a: assert property (@(posedge core_clk) disable iff (rst)
    (inc && clk_sel == gst_pkg::CS_INSTR) |=> !inc [*3])
    else $error("instruction clock counted too fast");

  presc_clr_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_count |=> (presc_cnt == '0))
    else $error("prescaler not cleared by count write");

  presc_div_a: assert property (@(posedge core_clk) disable iff (rst)
    (inc && presc_sel == 2'h3 && clk_sel == gst_pkg::CS_SYS && !wr_count)
      |=> !inc [*7])
    else $error("divide by eight broke");

  ext_disarm_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_sel == gst_pkg::CS_EXT && !arm_r && !wr_count) |=> $stable(count_r))
    else $error("external edge counted before falling edge");

  ovf_set_a: assert property (@(posedge core_clk) disable iff (rst)
    (ovf_event && ovf_mask_r) |=> (ovf_r && irq))
    else $error("overflow flag or interrupt missing");

  async_sleep_a: assert property (@(posedge core_clk) disable iff (rst)
    (sleep_mode && sync_dis && clk_sel == gst_pkg::CS_EXT && timer_on && !gate_en
     && presc_sel == 2'h0 && ext_rise && arm_r && !wr_count)
      |=> (count_r == $past(count_r) + 16'h0001))
    else $error("async count stalled in sleep");

  high_write_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_high |=> (count_r[15:8] == $past(wdata)) && (count_r[7:0] == $past(count_r[7:0])))
    else $error("high byte write not applied");

  read_low_a: assert property (@(posedge core_clk) disable iff (rst)
    (rd_en && addr == gst_pkg::ADDR_COUNT_LOW) |=> (rdata == $past(count_r[7:0])))
    else $error("low byte read not coherent");

  ovf_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
    ovf_event |=> (count_r == 16'h0000) && ovf_r)
    else $error("wrap did not reach zero with flag");

  ovf_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && addr == gst_pkg::ADDR_IRQ_STATUS && wdata[gst_pkg::IRQ_OVF_BIT] && !ovf_event)
      |=> !ovf_r)
    else $error("overflow flag not cleared by write");
endmodule

//--- gst_src_model.sv
// far-side model: count pin, slow oscillator and gate sources
`timescale 1ns/1ps
module gst_src_model (
  // clock
  input  wire logic core_clk,
  // count sources
  output logic      external_count_pin,
  output logic      slow_internal_oscillator,
  // gate sources
  output logic      gate_input_pin,
  output logic      other_timer_wrap_pulse,
  output logic      comparator_one_output,
  output logic      comparator_two_output
);
  logic [2:0] osc_cnt_r = 3'h0;

  // all sources idle low at time zero
  initial
  begin
    external_count_pin = 1'b0;
    slow_internal_oscillator = 1'b0;
    gate_input_pin = 1'b0;
    other_timer_wrap_pulse = 1'b0;
    comparator_one_output = 1'b0;
    comparator_two_output = 1'b0;
  end

  // free running slow oscillator, one rising edge per 16 cycles
  always @(posedge core_clk)
  begin
    osc_cnt_r <= osc_cnt_r + 3'h1;
    if (osc_cnt_r == 3'h7)
      slow_internal_oscillator <= ~slow_internal_oscillator;
  end

  // pin level held 4 cycles, long enough for the synchroniser
  task automatic pin_level(input logic v);
    @(posedge core_clk);
    external_count_pin <= v;
    repeat (4) @(posedge core_clk);
  endtask

  // whole pulses: a falling edge always precedes each rising edge
  task automatic pulses(input int n);
    repeat (n)
    begin
      pin_level(1'b0);
      pin_level(1'b1);
    end
  endtask

  // chosen source at v, the rest opposite so a wrong select shows
  task automatic set_gate(input logic [1:0] src, input logic v);
    logic [3:0] g;
    g = {4{~v}};
    g[src] = v;
    @(posedge core_clk);
    {comparator_two_output, comparator_one_output} <= g[3:2];
    {other_timer_wrap_pulse, gate_input_pin} <= g[1:0];
  endtask
endmodule

//--- gated_sixteen_bit_timer_test.sv
// self-checking bench for the gated sixteen bit timer
`timescale 1ns/1ps
module gated_sixteen_bit_timer_test;
  localparam logic [2:0] A_LO  = gst_pkg::ADDR_COUNT_LOW;
  localparam logic [2:0] A_HI  = gst_pkg::ADDR_COUNT_HIGH;
  localparam logic [2:0] A_CTL = gst_pkg::ADDR_TIMER_CTRL;
  localparam logic [2:0] A_GAT = gst_pkg::ADDR_GATE_CTRL;
  localparam logic [2:0] A_STS = gst_pkg::ADDR_IRQ_STATUS;
  localparam logic [2:0] A_MSK = gst_pkg::ADDR_IRQ_MASK;
  logic       core_clk;
  logic       rst;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rdata;
  logic       sleep_mode;
  logic       irq;
  logic       ext_pin, slow_osc, gate_pin, wrap_pls, cmp1_out, cmp2_out;
  int         error_cnt = 0;
  int         num_checks = 0;
  int         cyc = 0;

  gst_timer i_dut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .external_count_pin(ext_pin),
    .slow_internal_oscillator(slow_osc), .gate_input_pin(gate_pin),
    .other_timer_wrap_pulse(wrap_pls), .comparator_one_output(cmp1_out),
    .comparator_two_output(cmp2_out), .sleep_mode(sleep_mode), .irq(irq));

  gst_src_model i_src (.core_clk(core_clk), .external_count_pin(ext_pin),
    .slow_internal_oscillator(slow_osc), .gate_input_pin(gate_pin),
    .other_timer_wrap_pulse(wrap_pls), .comparator_one_output(cmp1_out),
    .comparator_two_output(cmp2_out));

  // 25 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // hang guard, the full run needs about 2700 cycles
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("BAD timeout expected 0 seen %0d", cyc);
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  // count within a tolerance: sync delays and prescaler phase blur the ends
  task automatic cmp_rng(input string what, input int exp, input int tol, input logic [15:0] got);
    num_checks++;
    if ($isunknown(got) || int'(got) < exp - tol || int'(got) > exp + tol)
    begin
      error_cnt++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  // only used with the timer stopped, so no wrap between the two reads
  task automatic rd_cnt(output logic [15:0] c);
    rd(A_LO, c[7:0]);
    rd(A_HI, c[15:8]);
  endtask

  task automatic clr_cnt();
    wr(A_LO, 8'h00);
    wr(A_HI, 8'h00);
  endtask

  task automatic t_reset();
    logic [7:0] d;
    cmp1("irq at reset", 1'b0, irq);
    wr(3'h7, 8'hFF);
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a), d);
      cmp8("reset or unmapped value", 8'h00, d);
    end
  endtask

  task automatic t_bytes();
    logic [15:0] c;
    wr(A_LO, 8'h34);
    wr(A_HI, 8'h12);
    wr(A_GAT, 8'h80);
    wr(A_CTL, 8'h40);
    wt(20);
    rd_cnt(c);
    cmp_rng("count with on bit clear", 'h1234, 0, c);
    wr(A_GAT, 8'h00);
  endtask

  task automatic t_clk();
    logic [15:0] c;
    int rate;
    for (int s = 0; s < 4; s++)
      for (int p = 0; p < 4; p++)
        if (s != 2)
        begin
          rate = (s == 1) ? 128 : (s == 0) ? 32 : 8;
          clr_cnt();
          wr(A_CTL, {2'(s), 2'(p), 4'h1});
          wt(126);
          wr(A_CTL, 8'h00);
          rd_cnt(c);
          cmp_rng("clock source count", rate >> p, 1, c);
        end
  endtask

  // leave four ticks in the divide by eight stage; a count write must drop them
  task automatic t_presc();
    logic [15:0] c;
    clr_cnt();
    wr(A_CTL, 8'h71);
    wt(2);
    wr(A_CTL, 8'h00);
    clr_cnt();
    wr(A_CTL, 8'h71);
    wt(10);
    wr(A_CTL, 8'h00);
    rd_cnt(c);
    cmp_rng("count after prescaler clear", 1, 0, c);
  endtask

  // first rise after enable has no fall before it and must be ignored
  task automatic t_ext();
    logic [15:0] c;
    for (int sd = 0; sd < 2; sd++)
    begin
      clr_cnt();
      i_src.pin_level(1'b0);
      sleep_mode <= 1'(sd);
      wr(A_CTL, {2'h2, 3'h0, 1'(sd), 2'h1});
      i_src.pin_level(1'b1);
      i_src.pulses(3);
      wt(10);
      sleep_mode <= 1'b0;
      wr(A_CTL, 8'h00);
      rd_cnt(c);
      cmp_rng("pin edge count", 3, 0, c);
    end
  endtask

  task automatic t_gate();
    logic [15:0] c;
    for (int g = 0; g < 4; g++)
      for (int p = 0; p < 2; p++)
      begin
        clr_cnt();
        i_src.set_gate(2'(g), ~1'(p));
        wr(A_GAT, {1'b1, 1'(p), 4'h0, 2'(g)});
        wr(A_CTL, 8'h41);
        wt(20);
        i_src.set_gate(2'(g), 1'(p));
        wt(40);
        i_src.set_gate(2'(g), ~1'(p));
        wt(20);
        wr(A_CTL, 8'h00);
        rd_cnt(c);
        cmp_rng("gated count", 41, 2, c);
      end
    wr(A_GAT, 8'h00);
  endtask

  task automatic t_ovf();
    logic [7:0] d;
    logic [15:0] c;
    wr(A_MSK, 8'h01);
    wr(A_LO, 8'hFE);
    wr(A_HI, 8'hFF);
    #1;
    cmp1("irq before wrap", 1'b0, irq);
    wr(A_CTL, 8'h41);
    wt(3);
    wr(A_CTL, 8'h00);
    rd_cnt(c);
    cmp_rng("count after wrap", 3, 1, c);
    cmp1("irq after wrap", 1'b1, irq);
    wr(A_STS, 8'h00);
    rd(A_STS, d);
    cmp8("flag after zero write", 8'h01, d);
    wr(A_MSK, 8'h00);
    #1;
    cmp1("irq masked", 1'b0, irq);
    wr(A_MSK, 8'h01);
    wr(A_STS, 8'h01);
    rd(A_STS, d);
    cmp8("flag after clear", 8'h00, d);
    cmp1("irq after clear", 1'b0, irq);
  endtask

  // reset for 12 cycles, then the scenarios in turn
  initial
  begin
    rst = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    sleep_mode = 1'b0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_bytes();
    t_clk();
    t_presc();
    t_ext();
    t_gate();
    t_ovf();
    results();
  end
endmodule
